// ### verilog/aea_pkg.sv
// Constants, types and state layout for the ACL / EEE indirect access block.
// Assumes a single pclk domain and an APB3 master with 32-bit data.
// Functional notes
// - Select 0x41..0x45 picks the ACL table, write direction, ports 1..5.
// - Select 0x51..0x55 picks the ACL table, read direction, ports 1..5.
// - ACL offset 0x10 holds the upper byte-enable mask byte, writable.
// - Offset 0x11 holds the lower mask byte; 0x3f/0xff enables all bytes.
// - Control write at 0x12 with type bit clear reads entry into buffer.
// - Read-done bit 5 sets when a read finishes; host polls it first.
// - Host fetches entry bytes 0x00..0x0d singly or as a burst.
// - Write-done bit 6 stays low while a table write is pending.
// - Data writes to 0x00..0x0d load the holding buffer only.
// - Control write with bit 4 set copies enabled buffer bytes to entry.
// - Mask bit i enables entry byte 13 minus i.
// - Entry layout depends on mode field in byte 0x01; bytes are opaque.
// - Select bits 7:5 = 001 with port 0 reaches the EEE globals.
// - Each 16-bit EEE register: even offset high byte, odd low byte.
// - Bit 7 of first EEE register lets input traffic cancel LPI request.
// - LPI requested after queue empty longer than wait, 1.3 ms units.
// - Third EEE register bits 3..0 enable next page, reset to one.
// - Done bits read 1 when idle or complete, 0 while in progress.
// - Four-bit entry field picks one of sixteen entries per port.
package aea_pkg;
    localparam int          ADDR_W       = 10;
    localparam int          NPORT        = 5;
    localparam int          NCOPPER      = 4;
    localparam int          NBYTE        = 14;
    localparam int          NENTRY       = 16;
    localparam int          PRE_W        = 20;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_SELECT   = 8'h6e;
    localparam logic [7:0]  IDX_OFFSET   = 8'h6f;
    localparam logic [7:0]  IDX_DATA     = 8'ha0;
    // Select register fields
    localparam logic [2:0]  SPACE_ACL    = 3'h2;
    localparam logic [2:0]  SPACE_EEE    = 3'h1;
    localparam logic [3:0]  PORT_GLOBAL  = 4'h0;
    localparam logic [3:0]  PORT_FIRST   = 4'h1;
    localparam logic [3:0]  PORT_LAST    = 4'h5;
    // ACL offsets
    localparam logic [7:0]  OFS_BYTE_LAST = 8'h0d;
    localparam logic [7:0]  OFS_MASK_HI  = 8'h10;
    localparam logic [7:0]  OFS_MASK_LO  = 8'h11;
    localparam logic [7:0]  OFS_CTRL     = 8'h12;
    localparam int          CTRL_WDONE   = 6;
    localparam int          CTRL_RDONE   = 5;
    localparam int          CTRL_TYPE    = 4;
    // EEE global offsets (high byte at even offset)
    localparam logic [7:0]  OFS_EEE_TERM = 8'h30;
    localparam logic [7:0]  OFS_EEE_WAIT = 8'h32;
    localparam logic [7:0]  OFS_EEE_NP   = 8'h34;
    localparam logic [7:0]  OFS_EEE_MIN  = 8'h36;
    localparam logic [7:0]  OFS_EEE_WAKE = 8'h38;
    localparam logic [7:0]  OFS_EEE_DIAG = 8'h3a;
    localparam int          TERM_BIT     = 7;
    localparam logic [15:0] TERM_FIXED   = 16'h4010;
    localparam logic [15:0] WAIT_RESET   = 16'h0010;
    localparam logic [15:0] NP_FIXED     = 16'h6800;
    localparam logic [3:0]  NP_RESET     = 4'hf;
    localparam logic [15:0] MIN_RESET    = 16'h0000;
    localparam logic [15:0] WAKE_VALUE   = 16'h0201;
    localparam logic [15:0] DIAG_VALUE   = 16'h0001;
    // LPI wait unit
    localparam real         UNIT_MS      = 1.3;
    localparam real         CLK_MHZ      = 200.0;
    localparam int          UNIT_CYCLES  = int'(UNIT_MS * CLK_MHZ * 1000.0);

    typedef enum logic [1:0] {
        AEA_IDLE   = 2'b00,
        AEA_BUSY   = 2'b01,
        AEA_COMMIT = 2'b11
    } aea_state_e;

    typedef struct packed {
        logic [7:0]                        sel;
        logic [7:0]                        ofs;
        logic [NPORT-1:0][NBYTE-1:0][7:0]  hold;
        logic [NPORT-1:0][NBYTE-1:0]       mask;
        logic [NPORT-1:0][4:0]             ctl;
        aea_state_e                        st;
        logic [2:0]                        op_port;
        logic                              op_wr;
        logic [3:0]                        op_entry;
        logic                              term_en;
        logic [15:0]                       wait_units;
        logic [3:0]                        np_en;
        logic [15:0]                       min_idle;
        logic [PRE_W-1:0]                  pre;
        logic [NCOPPER-1:0][15:0]          units;
        logic [NCOPPER-1:0]                lpi;
        logic [31:0]                       prdata;
    } aea_state_s;
endpackage : aea_pkg

// ### verilog/aea_indirect_access.sv
// ACL table and EEE global registers behind an indirect select/offset/data
// window, reached over APB. Assumes switch-core inputs on pclk.
`timescale 1ns/1ps
`default_nettype none
module aea_indirect_access #(
    parameter logic [aea_pkg::PRE_W-1:0] UNIT_CYCLES =
        aea_pkg::PRE_W'(aea_pkg::UNIT_CYCLES)
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [aea_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [aea_pkg::NCOPPER-1:0] txq_empty,
    input  wire logic [aea_pkg::NCOPPER-1:0] input_traffic,
    input  wire logic [aea_pkg::NCOPPER-1:0] eee_100_en,
    output logic      [aea_pkg::NCOPPER-1:0] lpi_request,
    output logic      [aea_pkg::NCOPPER-1:0] next_page_en
);
    aea_pkg::aea_state_s s_reg;
    aea_pkg::aea_state_s s_next;

    // Table storage: no reset, contents are defined only once written
    logic [7:0] table_mem [aea_pkg::NPORT*aea_pkg::NENTRY*aea_pkg::NBYTE];

    logic [7:0] idx;
    logic       mapped;
    logic       wr_acc;
    logic       rd_setup;
    logic       data_acc;
    logic [2:0] space;
    logic [3:0] port;
    logic       acl_sel;
    logic       acl_wdir;
    logic       eee_sel;
    logic [2:0] pidx;
    logic [7:0] rd_byte;
    logic       rdone;
    logic       wdone;
    logic       tick;
    logic       tbl_we;
    logic [6:0] tbl_base;
    logic [15:0] eee_reg;

    assign idx      = paddr[9:2];
    assign mapped   = (paddr[1:0] == 2'h0) &&
                      (idx == aea_pkg::IDX_SELECT ||
                       idx == aea_pkg::IDX_OFFSET ||
                       idx == aea_pkg::IDX_DATA);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign wr_acc   = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign data_acc = psel && penable && mapped && idx == aea_pkg::IDX_DATA;
    assign prdata   = s_reg.prdata;

    assign space    = s_reg.sel[7:5];
    assign port     = s_reg.sel[3:0];
    assign acl_sel  = space == aea_pkg::SPACE_ACL &&
                      port >= aea_pkg::PORT_FIRST &&
                      port <= aea_pkg::PORT_LAST;
    assign acl_wdir = acl_sel && !s_reg.sel[4];
    assign eee_sel  = space == aea_pkg::SPACE_EEE &&
                      port == aea_pkg::PORT_GLOBAL;
    assign pidx     = 3'(port - aea_pkg::PORT_FIRST);
    assign rdone    = !(s_reg.st != aea_pkg::AEA_IDLE && !s_reg.op_wr);
    assign wdone    = !(s_reg.st != aea_pkg::AEA_IDLE && s_reg.op_wr);
    assign tick     = s_reg.pre == UNIT_CYCLES - 1'b1;
    assign tbl_we   = s_reg.st == aea_pkg::AEA_COMMIT && s_reg.op_wr;
    assign tbl_base = {s_reg.op_port, s_reg.op_entry};

    // Pick the 16-bit EEE register of the current even/odd offset pair
    always_comb begin
        case ({s_reg.ofs[7:1], 1'b0})
            aea_pkg::OFS_EEE_TERM: eee_reg = aea_pkg::TERM_FIXED |
                {8'h00, s_reg.term_en, 7'h00};
            aea_pkg::OFS_EEE_WAIT: eee_reg = s_reg.wait_units;
            aea_pkg::OFS_EEE_NP:   eee_reg = aea_pkg::NP_FIXED |
                {12'h000, s_reg.np_en};
            aea_pkg::OFS_EEE_MIN:  eee_reg = s_reg.min_idle;
            aea_pkg::OFS_EEE_WAKE: eee_reg = aea_pkg::WAKE_VALUE;
            aea_pkg::OFS_EEE_DIAG: eee_reg = aea_pkg::DIAG_VALUE;
            default:               eee_reg = 16'h0000;
        endcase
    end

    // Byte seen through the data window
    always_comb begin
        rd_byte = 8'h00;
        if (acl_sel) begin
            if (s_reg.ofs <= aea_pkg::OFS_BYTE_LAST) begin
                rd_byte = s_reg.hold[pidx][s_reg.ofs[3:0]];
            end else if (s_reg.ofs == aea_pkg::OFS_MASK_HI) begin
                rd_byte = {2'h0, s_reg.mask[pidx][13:8]};
            end else if (s_reg.ofs == aea_pkg::OFS_MASK_LO) begin
                rd_byte = s_reg.mask[pidx][7:0];
            end else if (s_reg.ofs == aea_pkg::OFS_CTRL) begin
                rd_byte = {1'b0, wdone, rdone, s_reg.ctl[pidx]};
            end
        end else if (eee_sel) begin
            rd_byte = s_reg.ofs[0] ? eee_reg[7:0] : eee_reg[15:8];
        end
    end

    always_comb begin
        s_next = s_reg;
        // Read data is registered in the setup cycle, so pready can be 1
        if (rd_setup) begin
            case (idx)
                aea_pkg::IDX_SELECT: s_next.prdata = {24'h0, s_reg.sel};
                aea_pkg::IDX_OFFSET: s_next.prdata = {24'h0, s_reg.ofs};
                aea_pkg::IDX_DATA:   s_next.prdata = {24'h0, rd_byte};
                default:             s_next.prdata = 32'h0;
            endcase
        end
        if (wr_acc && idx == aea_pkg::IDX_SELECT) begin
            s_next.sel = pwdata[7:0];
        end
        if (wr_acc && idx == aea_pkg::IDX_OFFSET) begin
            s_next.ofs = pwdata[7:0];
        end
        // Burst: a data access at entry bytes 0x00..0x0c steps the offset on; 0x0d holds
        if (data_acc && acl_sel && s_reg.ofs < aea_pkg::OFS_BYTE_LAST) begin
            s_next.ofs = s_reg.ofs + 8'h01;
        end
        if (wr_acc && idx == aea_pkg::IDX_DATA && acl_wdir) begin
            if (s_reg.ofs <= aea_pkg::OFS_BYTE_LAST) begin
                s_next.hold[pidx][s_reg.ofs[3:0]] = pwdata[7:0];
            end else if (s_reg.ofs == aea_pkg::OFS_MASK_HI) begin
                s_next.mask[pidx][13:8] = pwdata[5:0];
            end else if (s_reg.ofs == aea_pkg::OFS_MASK_LO) begin
                s_next.mask[pidx][7:0] = pwdata[7:0];
            end else if (s_reg.ofs == aea_pkg::OFS_CTRL &&
                         s_reg.st == aea_pkg::AEA_IDLE) begin
                // A request while busy is dropped so an entry is not torn
                s_next.ctl[pidx] = pwdata[4:0];
                s_next.st        = aea_pkg::AEA_BUSY;
                s_next.op_port   = pidx;
                s_next.op_wr     = pwdata[aea_pkg::CTRL_TYPE];
                s_next.op_entry  = pwdata[3:0];
            end
        end
        if (wr_acc && idx == aea_pkg::IDX_DATA && eee_sel) begin
            case (s_reg.ofs)
                aea_pkg::OFS_EEE_TERM + 8'h01:
                    s_next.term_en = pwdata[aea_pkg::TERM_BIT];
                aea_pkg::OFS_EEE_WAIT:
                    s_next.wait_units[15:8] = pwdata[7:0];
                aea_pkg::OFS_EEE_WAIT + 8'h01:
                    s_next.wait_units[7:0] = pwdata[7:0];
                aea_pkg::OFS_EEE_NP + 8'h01:
                    s_next.np_en = pwdata[3:0];
                aea_pkg::OFS_EEE_MIN:
                    s_next.min_idle[15:8] = pwdata[7:0];
                aea_pkg::OFS_EEE_MIN + 8'h01:
                    s_next.min_idle[7:0] = pwdata[7:0];
                default: begin
                end
            endcase
        end
        // Table engine
        case (s_reg.st)
            aea_pkg::AEA_IDLE: begin
            end
            aea_pkg::AEA_BUSY: begin
                s_next.st = aea_pkg::AEA_COMMIT;
            end
            aea_pkg::AEA_COMMIT: begin
                s_next.st = aea_pkg::AEA_IDLE;
                if (!s_reg.op_wr) begin
                    for (int b = 0; b < aea_pkg::NBYTE; b++) begin
                        if (s_reg.mask[s_reg.op_port][aea_pkg::NBYTE-1-b]) begin
                            s_next.hold[s_reg.op_port][b] =
                                table_mem[int'(tbl_base) * aea_pkg::NBYTE + b];
                        end
                    end
                end
            end
            default: s_next.st = aea_pkg::AEA_IDLE;
        endcase
        // LPI request per copper port
        s_next.pre = tick ? '0 : s_reg.pre + 1'b1;
        for (int i = 0; i < aea_pkg::NCOPPER; i++) begin
            if (!txq_empty[i] || !eee_100_en[i] ||
                (s_reg.term_en && input_traffic[i])) begin
                s_next.units[i] = 16'h0000;
                s_next.lpi[i]   = 1'b0;
            end else begin
                if (tick && s_reg.units[i] != 16'hffff) begin
                    s_next.units[i] = s_reg.units[i] + 16'h0001;
                end
                if (s_reg.units[i] > s_reg.wait_units) begin
                    s_next.lpi[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg            <= '0;
            s_reg.st         <= aea_pkg::AEA_IDLE;
            s_reg.wait_units <= aea_pkg::WAIT_RESET;
            s_reg.np_en      <= aea_pkg::NP_RESET;
            s_reg.min_idle   <= aea_pkg::MIN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Only mask-enabled bytes reach the entry; disabled bytes keep their value
    always_ff @(posedge pclk) begin
        if (tbl_we) begin
            for (int b = 0; b < aea_pkg::NBYTE; b++) begin
                if (s_reg.mask[s_reg.op_port][aea_pkg::NBYTE-1-b]) begin
                    table_mem[int'(tbl_base) * aea_pkg::NBYTE + b] <=
                        s_reg.hold[s_reg.op_port][b];
                end
            end
        end
    end

    assign lpi_request  = s_reg.lpi;
    assign next_page_en = s_reg.np_en;

    sequence ctrl_write_s;
        wr_acc && idx == aea_pkg::IDX_DATA && acl_wdir &&
        s_reg.ofs == aea_pkg::OFS_CTRL && s_reg.st == aea_pkg::AEA_IDLE;
    endsequence

    sequence op_busy_s;
        s_reg.st == aea_pkg::AEA_BUSY ##1 s_reg.st == aea_pkg::AEA_COMMIT;
    endsequence

    chk_read_done_low: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_write_s and !pwdata[4] |=> !rdone [*2] ##1 rdone)
        else $error("read done bit not low for exactly two cycles");

    chk_write_done_low: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_write_s and pwdata[4] |=> op_busy_s and (!wdone [*2]) ##1 wdone)
        else $error("write done bit not low while write pending");

    chk_done_idle: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.st == aea_pkg::AEA_IDLE && acl_sel &&
        s_reg.ofs == aea_pkg::OFS_CTRL
        |-> rd_byte[aea_pkg::CTRL_WDONE] && rd_byte[aea_pkg::CTRL_RDONE])
        else $error("done bits not high when idle");

    chk_buffer_only: assert property (@(posedge pclk) disable iff (!presetn)
        !tbl_we |=> $stable(table_mem[0]))
        else $error("table changed without a write request");

    chk_select_acl: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && idx == aea_pkg::IDX_SELECT && pwdata[7:0] == 8'h43
        |=> acl_wdir && pidx == 3'h2)
        else $error("select 0x43 not decoded as ACL write port 3");

    chk_select_eee: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && idx == aea_pkg::IDX_SELECT && pwdata[7:0] == 8'h20
        |=> eee_sel && !acl_sel)
        else $error("select 0x20 not decoded as EEE global space");

    chk_mask_hi: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && idx == aea_pkg::IDX_DATA && acl_wdir &&
        s_reg.ofs == aea_pkg::OFS_MASK_HI
        |=> s_reg.mask[$past(pidx)][13:8] == $past(pwdata[5:0]))
        else $error("upper mask byte not updated");

    chk_lpi_cancel: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.term_en && input_traffic[0] |=> !lpi_request[0])
        else $error("input traffic did not withdraw LPI request");

    chk_lpi_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !txq_empty[1] |=> !lpi_request[1] && s_reg.units[1] == 16'h0000)
        else $error("LPI request with non-empty queue");

    chk_eee_pair: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && idx == aea_pkg::IDX_DATA && eee_sel &&
        s_reg.ofs == aea_pkg::OFS_EEE_WAIT
        |=> s_reg.wait_units[15:8] == $past(pwdata[7:0]))
        else $error("even EEE offset did not load high byte");

    // Mask and window decode
    chk_mask_lo: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && idx == aea_pkg::IDX_DATA && acl_wdir &&
        s_reg.ofs == aea_pkg::OFS_MASK_LO
        |=> s_reg.mask[$past(pidx)][7:0] == $past(pwdata[7:0]))
        else $error("lower mask byte not updated");

    chk_read_dir_ignore: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && idx == aea_pkg::IDX_DATA && acl_sel && !acl_wdir
        |=> $stable(s_reg.mask))
        else $error("data write in read direction changed a mask");

    chk_burst_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        data_acc && acl_sel && s_reg.ofs < aea_pkg::OFS_BYTE_LAST
        |=> s_reg.ofs == $past(s_reg.ofs) + 8'h01)
        else $error("burst access did not step the offset");

    chk_burst_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        data_acc && acl_sel && s_reg.ofs == aea_pkg::OFS_BYTE_LAST
        |=> s_reg.ofs == aea_pkg::OFS_BYTE_LAST)
        else $error("burst offset ran past the last entry byte");

    // Table engine copies, watched through byte 0x00 of the entry; then next page and LPI checks
    chk_entry_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        tbl_we && s_reg.mask[s_reg.op_port][aea_pkg::NBYTE-1]
        |=> table_mem[int'($past(tbl_base)) * aea_pkg::NBYTE] ==
            $past(s_reg.hold[s_reg.op_port][0]))
        else $error("enabled byte not copied into the entry");

    chk_entry_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        tbl_we && !s_reg.mask[s_reg.op_port][aea_pkg::NBYTE-1]
        |=> $stable(table_mem[int'(tbl_base) * aea_pkg::NBYTE]))
        else $error("disabled byte overwritten in the entry");

    chk_entry_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_reg.st == aea_pkg::AEA_COMMIT && !s_reg.op_wr &&
        s_reg.mask[s_reg.op_port][aea_pkg::NBYTE-1]
        |=> s_reg.hold[$past(s_reg.op_port)][0] ==
            $past(table_mem[int'(tbl_base) * aea_pkg::NBYTE]))
        else $error("enabled entry byte not read into the buffer");

    chk_np_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && idx == aea_pkg::IDX_DATA && eee_sel &&
        s_reg.ofs == aea_pkg::OFS_EEE_NP + 8'h01
        |=> next_page_en == $past(pwdata[3:0]))
        else $error("next page enables not written");

    chk_lpi_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        !s_reg.term_en && lpi_request[2] && txq_empty[2] && eee_100_en[2]
        |=> lpi_request[2])
        else $error("LPI request dropped while traffic may not cancel it");
endmodule : aea_indirect_access
`default_nettype wire

// ### test/aea_host_model.sv
// Host model: APB master doing byte accesses to the indirect window.
// Assumes an APB slave on pclk that may insert wait states.
`timescale 1ns/1ps
`default_nettype none
module aea_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0000_0000;
    end
    task apb(input logic w, input logic [9:0] a, input logic [7:0] d,
             output logic [7:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle data bus must not keep looking valid
        pwdata <= ~pwdata;
    endtask : apb
    task wreg(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        logic       e;
        apb(1'b1, {i, 2'b00}, d, q, e);
    endtask : wreg
    task rreg(input logic [7:0] i, output logic [7:0] q);
        logic e;
        apb(1'b0, {i, 2'b00}, 8'h00, q, e);
    endtask : rreg
    // Re-reads the control byte until its done bit is up, bounded
    task poll(input int b, output logic [7:0] first, output logic [7:0] q);
        int n;
        rreg(aea_pkg::IDX_DATA, first);
        q = first;
        for (n = 0; n < 20 && q[b] !== 1'b1; n++) begin
            rreg(aea_pkg::IDX_DATA, q);
        end
    endtask : poll
endmodule : aea_host_model
`default_nettype wire

// ### test/aea_indirect_access_test.sv
// Self-checking bench for the ACL / EEE indirect access block.
// Assumes the host model as APB master and a four-cycle LPI unit.
`timescale 1ns/1ps
`default_nettype none
module aea_indirect_access_test;
    localparam logic [7:0] EEE_RST [12] = '{8'h40, 8'h10, 8'h00, 8'h10,
        8'h68, 8'h0f, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h01};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  txq_empty;
    logic [3:0]  input_traffic;
    logic [3:0]  eee_100_en;
    logic [3:0]  lpi_request;
    logic [3:0]  next_page_en;
    logic [7:0]  q;
    logic [7:0]  q0;
    logic        e;
    int          n_errors;
    int          n_checks;
    int          cyc;
    int          tbl [1:5][16][14];
    int          hold [1:5][14];
    int          msk [1:5];

    aea_indirect_access #(.UNIT_CYCLES(20'h00004)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txq_empty(txq_empty),
        .input_traffic(input_traffic), .eee_100_en(eee_100_en),
        .lpi_request(lpi_request), .next_page_en(next_page_en));
    aea_host_model h (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            test_done();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, s, x);
        end
    endtask : chk
    task test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task put(input logic [7:0] o, input logic [7:0] d);
        h.wreg(aea_pkg::IDX_OFFSET, o);
        h.wreg(aea_pkg::IDX_DATA, d);
    endtask : put
    task get(input logic [7:0] o, output logic [7:0] d);
        h.wreg(aea_pkg::IDX_OFFSET, o);
        h.rreg(aea_pkg::IDX_DATA, d);
    endtask : get
    task set_mask(input int p, input int m);
        put(aea_pkg::OFS_MASK_HI, 8'(m >> 8));
        put(aea_pkg::OFS_MASK_LO, 8'(m));
        msk[p] = m;
    endtask : set_mask
    // Burst write relies on the offset stepping after each data access
    task load_buf(input int p);
        int i;
        h.wreg(aea_pkg::IDX_OFFSET, 8'h00);
        for (i = 0; i < 14; i++) begin
            hold[p][i] = $urandom % 256;
            h.wreg(aea_pkg::IDX_DATA, 8'(hold[p][i]));
        end
    endtask : load_buf
    task op(input int p, input int en, input logic w);
        int i;
        put(aea_pkg::OFS_CTRL, {3'b000, w, 4'(en)});
        h.poll(w ? 6 : 5, q0, q);
        chk(q0[w ? 6 : 5], 1'b0);
        chk(q, {3'b011, w, 4'(en)});
        for (i = 0; i < 14; i++) begin
            if (msk[p][13 - i] && w) tbl[p][en][i] = hold[p][i];
            if (msk[p][13 - i] && !w) hold[p][i] = tbl[p][en][i];
        end
    endtask : op
    task fetch(input int p);
        int i;
        h.wreg(aea_pkg::IDX_SELECT, 8'h50 | 8'(p));
        h.wreg(aea_pkg::IDX_OFFSET, 8'h00);
        for (i = 0; i < 14; i++) begin
            h.rreg(aea_pkg::IDX_DATA, q);
            chk(q, hold[p][i]);
        end
        get(aea_pkg::OFS_MASK_HI, q);
        chk(q, msk[p] >> 8);
        h.wreg(aea_pkg::IDX_DATA, 8'h00);
        h.rreg(aea_pkg::IDX_DATA, q);
        chk(q, msk[p] >> 8);
    endtask : fetch

    initial begin
        int r;
        int p;
        int en;
        presetn = 1'b0;
        txq_empty = 4'h0;
        input_traffic = 4'h0;
        eee_100_en = 4'hf;
        n_errors = 0;
        n_checks = 0;
        cyc = 0;
        void'($urandom(32'hcaf5));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk(next_page_en, 4'hf);
        chk(lpi_request, 4'h0);
        chk({pready, pslverr}, 2'b10);
        for (r = 0; r < 4; r++) begin
            p = (r == 0) ? 5 : (r == 1) ? 3 : 1 + $urandom % 5;
            en = (r == 0) ? 15 : $urandom % 16;
            h.wreg(aea_pkg::IDX_SELECT, 8'h40 | 8'(p));
            set_mask(p, 32'h3fff);
            load_buf(p);
            op(p, en, 1'b1);
            set_mask(p, (r == 0) ? 32'h1555 : $urandom % 16384);
            load_buf(p);
            op(p, en, 1'b1);
            load_buf(p);
            set_mask(p, 32'h3fff);
            op(p, en, 1'b0);
            fetch(p);
        end
        h.wreg(aea_pkg::IDX_SELECT, 8'h20);
        for (r = 0; r < 12; r++) begin
            get(8'h30 + 8'(r), q);
            chk(q, EEE_RST[r]);
        end
        put(8'h35, 8'h05);
        @(negedge pclk);
        chk(next_page_en, 4'h5);
        put(8'h32, 8'h00);
        put(8'h33, 8'h02);
        txq_empty <= 4'hf;
        repeat (8) @(posedge pclk);
        #1 chk(lpi_request, 4'h0);
        for (r = 0; r < 7 && lpi_request !== 4'hf; r++) begin
            @(posedge pclk);
            #1;
        end
        chk(lpi_request, 4'hf);
        @(posedge pclk);
        input_traffic <= 4'hf;
        repeat (4) @(posedge pclk);
        #1 chk(lpi_request, 4'hf);
        put(8'h31, 8'h80);
        repeat (2) @(posedge pclk);
        #1 chk(lpi_request, 4'h0);
        get(8'h31, q);
        chk(q, 8'h90);
        input_traffic <= 4'h0;
        repeat (16) @(posedge pclk);
        #1 chk(lpi_request, 4'hf);
        @(posedge pclk);
        eee_100_en <= 4'h0;
        repeat (2) @(posedge pclk);
        #1 chk(lpi_request, 4'h0);
        h.apb(1'b0, 10'h004, 8'h00, q, e);
        chk({e, q}, 9'h100);
        test_done();
    end
endmodule : aea_indirect_access_test
`default_nettype wire
